/* core/tcb_params.svh */
/*
 Constants for the timer channel B output block: register offsets, field
 positions, reset values. Assumes inclusion by its bare name.
*/
`ifndef TCB_PARAMS_SVH
`define TCB_PARAMS_SVH
`define TCB_ADDR_CTRL 3'h0
`define TCB_ADDR_CNT_LO 3'h1
`define TCB_ADDR_CNT_HI 3'h2
`define TCB_ADDR_CMPA_LO 3'h3
`define TCB_ADDR_CMPA_HI 3'h4
`define TCB_ADDR_CMPB_LO 3'h5
`define TCB_ADDR_CMPB_HI 3'h6
`define TCB_CTRL_RESET 8'h00
`define TCB_CMP_RESET 10'h000
`define TCB_MODE_POS 6
`define TCB_FUNC_POS 4
`define TCB_LVL_POS 3
`define TCB_INV_POS 2
`define TCB_ALIGN_POS 0
`endif

/* core/tcb_pkg.sv */
/*
 Types for the timer channel B output block. Assumes tcb_params.svh.
*/
`default_nettype none
package tcb_pkg;
    typedef enum logic [1:0] {
        TCB_MODE_COMPARE,
        TCB_MODE_CAPTURE,
        TCB_MODE_PWM,
        TCB_MODE_TIMER
    } tcb_mode_t;
    typedef enum logic [1:0] {
        TCB_ALIGN_EDGE,
        TCB_ALIGN_UP,
        TCB_ALIGN_DOWN,
        TCB_ALIGN_BOTH
    } tcb_align_t;
endpackage : tcb_pkg
`default_nettype wire

/* core/tcb_channel.sv */
/*
 Channel B of the 10-bit timer: control byte, counter and compare byte
 registers, pin output logic and capture trigger detection.
 Assumes the counter core supplies the count, match strobes, direction,
 period start and run bit, all on clk_in.
*/
`timescale 1ns/1ps
`include "tcb_params.svh"
`default_nettype none
module tcb_channel
    import tcb_pkg::*;
#(
    parameter int CNT_W = 10
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // register port
    input wire logic [2:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    // timer core
    input wire logic timer_run_bit_in,
    input wire logic [CNT_W-1:0] count_in,
    input wire logic match_b_in,
    input wire logic count_down_in,
    input wire logic period_start_in,
    output logic [CNT_W-1:0] compare_a_value_out,
    output logic [CNT_W-1:0] compare_b_value_out,
    output logic [1:0] mode_out,
    output logic [1:0] align_out,
    output logic capture_out,
    // channel pins
    input wire logic [2:0] chb_pin_in,
    output logic [2:0] chb_pin_out,
    output logic [2:0] chb_pin_oe_n_out
);
    logic [7:0] ctrl, next_ctrl;
    logic [CNT_W-1:0] cmpa, next_cmpa, cmpb, next_cmpb;
    logic [7:0] rdata, next_rdata;
    logic run_d, lvl, next_lvl, pulse_done, next_pulse_done;
    logic [2:0] pin_s1, pin_s2, pin_s3;
    logic [2:0] pin_q, next_pin_q, oe_n, next_oe_n;
    logic cap, next_cap;
    tcb_mode_t mode;
    logic [1:0] func;
    logic oc, inv, run_rise, match_ok;

    // byte views of a 10-bit value; upper bits of a high byte read zero
    function automatic logic [7:0] lo_byte(input logic [CNT_W-1:0] val);
        lo_byte = val[7:0];
    endfunction : lo_byte

    function automatic logic [7:0] hi_byte(input logic [CNT_W-1:0] val);
        hi_byte = {6'h00, val[9:8]};
    endfunction : hi_byte

    // field views of the control byte
    assign mode = tcb_mode_t'(ctrl[`TCB_MODE_POS +: 2]);
    assign func = ctrl[`TCB_FUNC_POS +: 2];
    assign oc = ctrl[`TCB_LVL_POS];
    assign inv = ctrl[`TCB_INV_POS];
    assign run_rise = timer_run_bit_in & ~run_d;

    // match qualified by alignment direction
    always_comb begin
        case (tcb_align_t'(ctrl[`TCB_ALIGN_POS +: 2]))
            TCB_ALIGN_EDGE: match_ok = match_b_in;
            TCB_ALIGN_UP: match_ok = match_b_in & ~count_down_in;
            TCB_ALIGN_DOWN: match_ok = match_b_in & count_down_in;
            TCB_ALIGN_BOTH: match_ok = match_b_in;
            default: match_ok = match_b_in;
        endcase
    end

    // register writes and read data, one cycle later
    always_comb begin
        next_ctrl = ctrl;
        next_cmpa = cmpa;
        next_cmpb = cmpb;
        next_rdata = 8'h00;
        if (wr_in) begin
            case (addr_in)
                `TCB_ADDR_CTRL: next_ctrl = wdata_in;
                `TCB_ADDR_CMPA_LO: next_cmpa[7:0] = wdata_in;
                `TCB_ADDR_CMPA_HI: next_cmpa[9:8] = wdata_in[1:0];
                `TCB_ADDR_CMPB_LO: next_cmpb[7:0] = wdata_in;
                `TCB_ADDR_CMPB_HI: next_cmpb[9:8] = wdata_in[1:0];
                default: next_ctrl = ctrl;
            endcase
        end
        if (rd_in) begin
            // upper bits of high bytes stay zero
            case (addr_in)
                `TCB_ADDR_CTRL: next_rdata = ctrl;
                `TCB_ADDR_CNT_LO: next_rdata = lo_byte(count_in);
                `TCB_ADDR_CNT_HI: next_rdata = hi_byte(count_in);
                `TCB_ADDR_CMPA_LO: next_rdata = lo_byte(cmpa);
                `TCB_ADDR_CMPA_HI: next_rdata = hi_byte(cmpa);
                `TCB_ADDR_CMPB_LO: next_rdata = lo_byte(cmpb);
                `TCB_ADDR_CMPB_HI: next_rdata = hi_byte(cmpb);
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            ctrl <= `TCB_CTRL_RESET;
            cmpa <= `TCB_CMP_RESET;
            cmpb <= `TCB_CMP_RESET;
            rdata <= 8'h00;
        end else begin
            ctrl <= next_ctrl;
            cmpa <= next_cmpa;
            cmpb <= next_cmpb;
            rdata <= next_rdata;
        end
    end

    // internal pin level before polarity; level is active-high in pwm terms
    always_comb begin
        next_lvl = lvl;
        next_pulse_done = pulse_done;
        case (mode)
            TCB_MODE_COMPARE: begin
                if (run_rise) begin
                    next_lvl = oc;
                end else if (match_ok && timer_run_bit_in) begin
                    // same level as initial gives no change
                    case (func)
                        2'h0: next_lvl = lvl;
                        2'h1: next_lvl = 1'b0;
                        2'h2: next_lvl = 1'b1;
                        default: next_lvl = ~lvl;
                    endcase
                end
            end
            TCB_MODE_PWM: begin
                // active state held in lvl, mapped by oc at the pin
                if (run_rise) begin
                    next_pulse_done = 1'b0;
                end
                case (func)
                    2'h0: next_lvl = 1'b0;
                    2'h1: next_lvl = 1'b1;
                    2'h2: begin
                        if (period_start_in) begin
                            next_lvl = 1'b1;
                        end else if (match_ok) begin
                            next_lvl = 1'b0;
                        end
                    end
                    default: begin
                        if (run_rise) begin
                            next_lvl = 1'b1;
                        end else if (match_ok || !timer_run_bit_in) begin
                            next_lvl = 1'b0;
                            next_pulse_done = 1'b1;
                        end else if (pulse_done) begin
                            // one pulse per run rise, however long the run lasts
                            next_lvl = 1'h0;
                        end
                    end
                endcase
            end
            default: next_lvl = lvl;
        endcase
    end

    // pin drive: polarity applied, active level too in pwm only, identical on all three pins
    always_comb begin
        next_pin_q = 3'h0;
        next_oe_n = 3'h7;
        case (mode)
            TCB_MODE_COMPARE: begin
                next_pin_q = {3{next_lvl ^ inv}};
                next_oe_n = 3'h0;
            end
            TCB_MODE_PWM: begin
                next_pin_q = {3{(next_lvl ~^ oc) ^ inv}};
                next_oe_n = 3'h0;
            end
            default: next_oe_n = 3'h7; // pins released
        endcase
    end

    // capture edge detect on synchronised pins, any pin triggers
    // limitation: entering capture from a driven low pin may log one rising
    // edge as the released pin goes to its outside level
    always_comb begin
        next_cap = 1'b0;
        if (mode == TCB_MODE_CAPTURE) begin
            case (func)
                2'h0: next_cap = |(pin_s2 & ~pin_s3);
                2'h1: next_cap = |(~pin_s2 & pin_s3);
                2'h2: next_cap = |(pin_s2 ^ pin_s3);
                default: next_cap = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            run_d <= 1'b0;
            lvl <= 1'b0;
            pulse_done <= 1'b0;
            pin_s1 <= 3'h0;
            pin_s2 <= 3'h0;
            pin_s3 <= 3'h0;
            pin_q <= 3'h0;
            oe_n <= 3'h7;
            cap <= 1'b0;
        end else begin
            run_d <= timer_run_bit_in;
            lvl <= next_lvl;
            pulse_done <= next_pulse_done;
            pin_s1 <= chb_pin_in;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            pin_q <= next_pin_q;
            oe_n <= next_oe_n;
            cap <= next_cap;
        end
    end

    // outputs straight from flip-flops
    assign rdata_out = rdata;
    assign compare_a_value_out = cmpa;
    assign compare_b_value_out = cmpb;
    assign mode_out = ctrl[`TCB_MODE_POS +: 2];
    assign align_out = ctrl[`TCB_ALIGN_POS +: 2];
    assign capture_out = cap;
    assign chb_pin_out = pin_q;
    assign chb_pin_oe_n_out = oe_n;

    // checks; all but a_pin_same look one cycle after their cause, at registered state
    a_run_restart: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (mode == TCB_MODE_COMPARE && run_rise) |=> (lvl == $past(oc)))
        else $error("run rise did not restore initial level");
    a_hold_func: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (mode == TCB_MODE_COMPARE && func == 2'h0 && !run_rise) |=> $stable(lvl))
        else $error("level moved with function zero");
    a_toggle_match: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (mode == TCB_MODE_COMPARE && func == 2'h3 && match_ok && timer_run_bit_in
         && !run_rise) |=> (lvl != $past(lvl)))
        else $error("toggle missing");
    a_pin_same: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (pin_q == 3'h0) || (pin_q == 3'h7))
        else $error("pins differ");
    a_pin_polarity: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (mode == TCB_MODE_COMPARE) |=> (pin_q[0] == (lvl ^ $past(inv))))
        else $error("polarity wrong");
    a_timer_release: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (mode == TCB_MODE_TIMER) |=> (oe_n == 3'h7))
        else $error("pins driven in timer mode");
    a_pwm_force: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (mode == TCB_MODE_PWM && func == 2'h1) |=> (pin_q[0] == ($past(oc) ^ $past(inv))))
        else $error("forced active level wrong");
    a_cap_disabled: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (func == 2'h3 || mode != TCB_MODE_CAPTURE) |=> !cap)
        else $error("capture while disabled");
    a_capture_release: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (mode == TCB_MODE_CAPTURE) |=> (oe_n == 3'h7))
        else $error("pins driven in capture mode");
    a_hi_zero: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (rd_in && addr_in == `TCB_ADDR_CNT_HI) |=> (rdata_out[7:2] == 6'h00))
        else $error("high byte upper bits set");
    a_align_gate: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (mode == TCB_MODE_PWM && func == 2'h2 && !period_start_in && count_down_in
         && ctrl[`TCB_ALIGN_POS +: 2] == 2'h1) |=> $stable(lvl))
        else $error("down count match acted in count up alignment");
    a_single_end: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (mode == TCB_MODE_PWM && func == 2'h3 && !run_rise && !timer_run_bit_in) |=> !lvl)
        else $error("single pulse active with timer stopped");
    a_pulse_hold: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (mode == TCB_MODE_PWM && func == 2'h3 && pulse_done && !run_rise) |=> !lvl)
        else $error("second pulse without run rise");
    a_rdata_idle: assert property (@(posedge clk_in) disable iff (!nrst_in)
        !rd_in |=> (rdata_out == 8'h00))
        else $error("read data stood past its cycle");
    a_cnt_lo_read: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (rd_in && addr_in == `TCB_ADDR_CNT_LO) |=> (rdata_out == lo_byte($past(count_in))))
        else $error("counter low byte read wrong");
    a_cnt_hi_read: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (rd_in && addr_in == `TCB_ADDR_CNT_HI) |=> (rdata_out == hi_byte($past(count_in))))
        else $error("counter high byte read wrong");
    a_cmpb_write: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (wr_in && addr_in == `TCB_ADDR_CMPB_LO) |=> (cmpb[7:0] == $past(wdata_in)))
        else $error("compare b low byte write lost");
    a_cmpa_hi_write: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (wr_in && addr_in == `TCB_ADDR_CMPA_HI)
        |=> (hi_byte(cmpa) == ($past(wdata_in) & 8'h03)))
        else $error("compare a high byte write lost");
    c_toggle: cover property (@(posedge clk_in) disable iff (!nrst_in)
        mode == TCB_MODE_COMPARE && func == 2'h3 && match_ok ##1 run_rise);
    c_pwm_wave: cover property (@(posedge clk_in) disable iff (!nrst_in)
        mode == TCB_MODE_PWM && func == 2'h2 && period_start_in ##[1:20] match_ok);
    c_capture: cover property (@(posedge clk_in) disable iff (!nrst_in) cap);
    c_single_pulse: cover property (@(posedge clk_in) disable iff (!nrst_in)
        mode == TCB_MODE_PWM && func == 2'h3 && run_rise ##1 lvl ##[1:20] !lvl);
    c_timer_match: cover property (@(posedge clk_in) disable iff (!nrst_in)
        mode == TCB_MODE_TIMER && match_b_in);
endmodule : tcb_channel
`default_nettype wire

/* verif/tcb_pin_model.sv */
/*
 pin model: the outside world on the three channel B pins.
 assumes oe_n low means the block drives the pin.
*/
`timescale 1ns/1ps
`default_nettype none
module tcb_pin_model (
    // block side
    input wire logic [2:0] pin_out_in,
    input wire logic [2:0] pin_oe_n_in,
    // bench side
    input wire logic ext_level_in,
    output logic [2:0] pin_level_out
);
    // released pins follow the outside driver, never a stale block value
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            pin_level_out[i] = pin_oe_n_in[i] ? ext_level_in : pin_out_in[i];
        end
    end
endmodule : tcb_pin_model
`default_nettype wire

/* verif/tcb_channel_bench.sv */
/*
 bench for channel B: register port tasks, compare, pwm, capture, timer.
 assumes tcb_pin_model on the pins and the control layout of the params.
*/
`timescale 1ns/1ps
`include "tcb_params.svh"
`default_nettype none
module tcb_channel_bench;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic run = 1'b0;
    logic match = 1'b0;
    logic down = 1'b0;
    logic pstart = 1'b0;
    logic ext = 1'b1;
    logic [9:0] count = 10'h2a5;
    logic [7:0] rdata;
    logic [9:0] cmp_a, cmp_b;
    logic [1:0] mode_o, align_o;
    logic cap;
    logic [2:0] pin, oe_n, pin_lvl;
    int failures = 0;
    int check_count = 0;
    int caps = 0;

    tcb_channel dut_u (.clk_in(clk), .nrst_in(nrst), .addr_in(addr), .wdata_in(wdata),
        .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .timer_run_bit_in(run),
        .count_in(count), .match_b_in(match), .count_down_in(down),
        .period_start_in(pstart), .compare_a_value_out(cmp_a), .compare_b_value_out(cmp_b),
        .mode_out(mode_o), .align_out(align_o), .capture_out(cap), .chb_pin_in(pin_lvl),
        .chb_pin_out(pin), .chb_pin_oe_n_out(oe_n));
    tcb_pin_model pins_u (.pin_out_in(pin), .pin_oe_n_in(oe_n), .ext_level_in(ext),
        .pin_level_out(pin_lvl));

    initial begin
        forever #25 clk = ~clk;
    end
    // capture pulses counted, so a scenario compares deltas
    always @(posedge clk) begin
        if (cap === 1'b1) begin
            caps <= caps + 1;
        end
    end

    task automatic chk(input string name, input logic [9:0] exp, input logic [9:0] got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic stop_test();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : stop_test
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk("rdata", {2'h0, exp}, {2'h0, rdata});
    endtask : rd_reg
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    // one cycle strobe: period start or match
    task automatic strobe(input logic per);
        @(posedge clk);
        if (per) begin
            pstart <= 1'b1;
        end else begin
            match <= 1'b1;
        end
        @(posedge clk);
        pstart <= 1'b0;
        match <= 1'b0;
        #1;
    endtask : strobe
    // control only rewritten with the timer stopped, then run rises
    task automatic cfg(input logic [7:0] c);
        @(posedge clk);
        run <= 1'b0;
        wr_reg(`TCB_ADDR_CTRL, c);
        @(posedge clk);
        run <= 1'b1;
        tick(3);
    endtask : cfg
    task automatic pins(input logic e);
        chk("pins", {4'h0, 3'h0, {3{e}}}, {4'h0, oe_n, pin});
    endtask : pins

    initial begin
        logic [1:0] f;
        logic l, v, e, q;
        int b;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            rd_reg(i[2:0], (i == 1) ? 8'ha5 : (i == 2) ? 8'h02 : 8'h00);
        end
        wr_reg(`TCB_ADDR_CMPA_LO, 8'hff);
        wr_reg(`TCB_ADDR_CMPA_HI, 8'hff);
        wr_reg(`TCB_ADDR_CMPB_LO, 8'h5a);
        wr_reg(`TCB_ADDR_CMPB_HI, 8'hfe);
        wr_reg(`TCB_ADDR_CNT_LO, 8'h00);
        // a new count shows the counter bytes follow the core, not the write
        @(posedge clk);
        count <= 10'h15a;
        rd_reg(`TCB_ADDR_CMPA_LO, 8'hff);
        rd_reg(`TCB_ADDR_CMPA_HI, 8'h03);
        rd_reg(`TCB_ADDR_CMPB_LO, 8'h5a);
        rd_reg(`TCB_ADDR_CMPB_HI, 8'h02);
        rd_reg(`TCB_ADDR_CNT_LO, 8'h5a);
        rd_reg(`TCB_ADDR_CNT_HI, 8'h01);
        chk("cmp_a", 10'h3ff, cmp_a);
        chk("cmp_b", 10'h25a, cmp_b);
        // compare mode: every function, initial level and polarity
        for (int i = 0; i < 16; i++) begin
            f = i[1:0];
            l = i[2];
            v = i[3];
            cfg({2'h0, f, l, v, 2'h0});
            pins(l ^ v);
            strobe(1'b0);
            e = (f == 2'h0) ? l : (f == 2'h3) ? ~l : f[1];
            pins(e ^ v);
        end
        // pwm wave: every alignment against both count directions
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            down <= i[2];
            cfg({2'h2, 2'h2, 1'b1, 1'b0, i[1:0]});
            chk("align", {8'h0, i[1:0]}, {8'h0, align_o});
            strobe(1'b1);
            pins(1'b1);
            strobe(1'b0);
            q = (i[1:0] == 2'h0) || (i[1:0] == 2'h3) || (i[1:0] == {i[2], ~i[2]});
            pins(~q);
        end
        // forced states and single pulse, active low
        for (int i = 0; i < 3; i++) begin
            f = (i == 2) ? 2'h3 : i[1:0];
            cfg({2'h2, f, 1'b0, 1'b0, 2'h0});
            pins(f == 2'h0);
            strobe(1'b0);
            pins(f != 2'h1);
        end
        // capture edges; outside level stays high across the release
        for (int i = 0; i < 4; i++) begin
            cfg({2'h1, i[1:0], 4'h0});
            b = caps;
            @(posedge clk);
            ext <= 1'b0;
            tick(8);
            chk("fall caps", {9'h0, i == 1 || i == 2}, 10'(caps - b));
            b = caps;
            @(posedge clk);
            ext <= 1'b1;
            tick(8);
            chk("rise caps", {9'h0, i == 0 || i == 2}, 10'(caps - b));
        end
        cfg({2'h3, 2'h1, 1'b1, 1'b1, 2'h0});
        chk("mode", 10'h003, {8'h0, mode_o});
        strobe(1'b0);
        chk("timer oe_n", 10'h007, {7'h0, oe_n});
        chk("timer pins", 10'h007, {7'h0, pin_lvl});
        stop_test();
    end
    // hang guard
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        stop_test();
    end
endmodule : tcb_channel_bench
`default_nettype wire
